// >>> wdt_pkg.sv
// Purpose: Shared constants for the sleep-aware watchdog
// Assumes: 25 MHz core clock
// Notes:   Period select counts powers of two of the 1 ms base tick
package watchdog_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Period select
  // ----------------------------------------------------------------
  localparam int         SEL_W       = 5;
  localparam int         CNT_W       = 19;
  localparam logic [4:0] SEL_MAX     = 5'h12;
  localparam logic [4:0] SEL_DEFAULT = 5'h0B;

  // ----------------------------------------------------------------
  // Enable configuration codes
  // ----------------------------------------------------------------
  localparam logic [1:0] EN_OFF      = 2'h0;
  localparam logic [1:0] EN_SOFTWARE = 2'h1;
  localparam logic [1:0] EN_RUN_ONLY = 2'h2;
  localparam logic [1:0] EN_ALWAYS   = 2'h3;

  // ----------------------------------------------------------------
  // System clock source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLK_SECONDARY_OSC   = 3'h0;
  localparam logic [2:0] CLK_EXTERNAL_RC     = 3'h1;
  localparam logic [2:0] CLK_INTERNAL_OSC    = 3'h2;
  localparam logic [2:0] CLK_EXTERNAL_INPUT  = 3'h3;
  localparam logic [2:0] CLK_MEDIUM_CRYSTAL  = 3'h4;
  localparam logic [2:0] CLK_HIGH_SPEED_XTAL = 3'h5;
  localparam logic [2:0] CLK_LOW_POWER_XTAL  = 3'h6;

  typedef enum logic [1:0] {
    RUN_ST,
    SLEEP_ST,
    STARTUP_HOLD_ST
  } sleep_state_e;

endpackage

// >>> wdt_tick_if.sv
// Purpose: Carrier between watchdog control and its base tick divider
// Assumes: One clock domain
// Notes:   clr restarts the divider, tick is a one-cycle pulse
`timescale 1ns/1ps
interface tick_if;
  logic clr;
  logic tick;
  modport src  (input clr, output tick);
  modport sink (output clr, input tick);
endinterface

// >>> wdt_prescaler.sv
// Purpose: Divide the core clock down to the watchdog base tick
// Assumes: clr arrives with every watchdog counter clear
// Notes:   Clearing the divider too keeps the first period full length
`timescale 1ns/1ps
module tick_prescaler #(
  parameter int DIV = 25000
) (
  input  wire logic  clk,
  input  wire logic  arst_n,
  tick_if.src        tk
);

  localparam int W = $clog2(DIV);

  logic [W-1:0] div_r;
  logic         tick_r;
  wire          wrap = (div_r == W'(DIV - 1));
  wire  [W-1:0] div_nxt = (tk.clr || wrap) ? '0 : div_r + W'(1);

  initial begin
    if (DIV < 2) $error("DIV must be at least 2");
  end

  assign tk.tick = tick_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= wrap && !tk.clr;
    end
  end

endmodule

// >>> sleep_aware_watchdog.sv
// Purpose: Watchdog counter with Sleep handling, wake and status flags
// Assumes: Control inputs synchronous to clk, pulses one cycle wide
// Notes:   Period is 1 ms times two to the power of the period select
`timescale 1ns/1ps
module sleep_aware_watchdog
  import watchdog_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [1:0]       watchdog_enable_config,
  input  wire logic             software_watchdog_enable,
  input  wire logic [SEL_W-1:0] watchdog_period_select,
  input  wire logic             period_load,
  input  wire logic [2:0]       system_clock_sel,
  input  wire logic             sleep_request,
  input  wire logic             wake_request,
  input  wire logic             oscillator_startup_timer_done,
  input  wire logic             watchdog_clear_instruction,
  input  wire logic             oscillator_fail,
  output logic [CNT_W-1:0]      watchdog_counter_r,
  output logic                  sleeping_r,
  output logic                  wake_r,
  output logic                  watchdog_reset_r,
  output logic                  timeout_flag_r,
  output logic                  powerdown_flag_r
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (TICK_DIV < 2) $error("TICK_DIV must be at least 2");
    if (CNT_W < 32'(SEL_MAX) + 1) $error("CNT_W too small for SEL_MAX");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  sleep_state_e     state_r;
  sleep_state_e     state_nxt;
  logic [SEL_W-1:0] sel_r;
  tick_if           tk ();

  wire in_run   = (state_r == RUN_ST);
  wire in_sleep = (state_r == SLEEP_ST);
  wire in_hold  = (state_r == STARTUP_HOLD_ST);

  // Config 10 counts only in run state, so Sleep keeps it at zero
  wire active = (watchdog_enable_config == EN_ALWAYS)
             || (watchdog_enable_config == EN_SOFTWARE
                 && software_watchdog_enable)
             || (watchdog_enable_config == EN_RUN_ONLY
                 && in_run);

  wire crystal = (system_clock_sel == CLK_MEDIUM_CRYSTAL)
              || (system_clock_sel == CLK_HIGH_SPEED_XTAL)
              || (system_clock_sel == CLK_LOW_POWER_XTAL);

  // Values beyond the longest period are clamped rather than wrapped
  wire [SEL_W-1:0] sel_clamped = (watchdog_period_select > SEL_MAX)
                               ? SEL_MAX : watchdog_period_select;
  wire [CNT_W-1:0] limit_m1 = (CNT_W'(1) << sel_r) - CNT_W'(1);

  wire expire       = active && tk.tick
                   && (watchdog_counter_r == limit_m1);
  wire enter_sleep  = in_run && sleep_request;
  wire expire_sleep = in_sleep && expire;
  wire exit_sleep   = in_sleep && (wake_request || expire);

  // Divider changes are not a clear term on purpose
  wire clear_cnt = !active
                || watchdog_clear_instruction
                || oscillator_fail
                || enter_sleep
                || exit_sleep
                || in_hold;

  wire expire_run = in_run && expire && !clear_cnt;

  wire [CNT_W-1:0] cnt_nxt = clear_cnt ? '0
                           : expire ? '0
                           : tk.tick ? watchdog_counter_r + CNT_W'(1)
                           : watchdog_counter_r;

  assign tk.clr = clear_cnt || expire;

  tick_prescaler #(
    .DIV (TICK_DIV)
  ) u_prescaler (
    .clk    (clk),
    .arst_n (arst_n),
    .tk     (tk)
  );

  // ----------------------------------------------------------------
  // Sleep sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RUN_ST: begin
        if (enter_sleep) state_nxt = SLEEP_ST;
      end
      SLEEP_ST: begin
        if (exit_sleep) begin
          state_nxt = crystal ? STARTUP_HOLD_ST : RUN_ST;
        end
      end
      STARTUP_HOLD_ST: begin
        if (oscillator_startup_timer_done) state_nxt = RUN_ST;
      end
      default: state_nxt = RUN_ST;
    endcase
  end

  // Sleep time-out wakes, it never resets; flags tell the cause
  wire expire_any = expire_sleep || expire_run;
  wire timeout_flag_nxt = expire_any ? 1'b0
                        : enter_sleep ? 1'b1
                        : watchdog_clear_instruction ? 1'b1
                        : timeout_flag_r;
  wire powerdown_flag_nxt = expire_sleep ? 1'b0
                          : enter_sleep ? 1'b0
                          : watchdog_clear_instruction ? 1'b1
                          : powerdown_flag_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r            <= RUN_ST;
      sel_r              <= SEL_DEFAULT;
      watchdog_counter_r <= '0;
      timeout_flag_r     <= 1'b1;
      powerdown_flag_r   <= 1'b1;
      sleeping_r         <= 1'b0;
      wake_r             <= 1'b0;
      watchdog_reset_r   <= 1'b0;
    end else begin
      state_r            <= state_nxt;
      sel_r              <= period_load ? sel_clamped : sel_r;
      watchdog_counter_r <= cnt_nxt;
      timeout_flag_r     <= timeout_flag_nxt;
      powerdown_flag_r   <= powerdown_flag_nxt;
      sleeping_r         <= (state_nxt == SLEEP_ST);
      wake_r             <= exit_sleep;
      watchdog_reset_r   <= expire_run;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_entry_clear;
    enter_sleep |=> watchdog_counter_r == '0;
  endproperty
  a_entry_clear: assert property (p_entry_clear)
    else $error("Counter not cleared on Sleep entry");

  property p_resume;
    in_sleep && watchdog_enable_config == EN_ALWAYS && tk.tick
      && watchdog_counter_r == '0 && !wake_request && sel_r != '0
      && !watchdog_clear_instruction && !oscillator_fail
      |=> watchdog_counter_r == CNT_W'(1);
  endproperty
  a_resume: assert property (p_resume)
    else $error("Counter did not resume in Sleep");

  property p_exit_clear;
    exit_sleep |=> watchdog_counter_r == '0 && wake_r;
  endproperty
  a_exit_clear: assert property (p_exit_clear)
    else $error("Counter not cleared on Sleep exit");

  property p_startup_hold;
    exit_sleep && crystal |=> in_hold && watchdog_counter_r == '0
      ##1 (watchdog_counter_r == '0);
  endproperty
  a_startup_hold: assert property (p_startup_hold)
    else $error("Counter moved during start-up hold");

  property p_sleep_no_reset;
    expire_sleep |=> !watchdog_reset_r && wake_r && !sleeping_r;
  endproperty
  a_sleep_no_reset: assert property (p_sleep_no_reset)
    else $error("Sleep time-out did not wake cleanly");

  property p_sleep_flags;
    expire_sleep |=> !timeout_flag_r && !powerdown_flag_r;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("Flags wrong after Sleep time-out");

  property p_disabled;
    watchdog_enable_config == EN_OFF [*2] |-> watchdog_counter_r == '0;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Counter moved while disabled");

  property p_run_only;
    sleeping_r && watchdog_enable_config == EN_RUN_ONLY
      |=> watchdog_counter_r == '0;
  endproperty
  a_run_only: assert property (p_run_only)
    else $error("Run-only watchdog counted in Sleep");

  property p_clear_instr;
    watchdog_clear_instruction || oscillator_fail
      |=> watchdog_counter_r == '0;
  endproperty
  a_clear_instr: assert property (p_clear_instr)
    else $error("Counter not cleared by clear or oscillator fail");

  property p_run_reset;
    expire_run |=> watchdog_reset_r && !timeout_flag_r ##1 !watchdog_reset_r;
  endproperty
  a_run_reset: assert property (p_run_reset)
    else $error("Running time-out did not pulse reset");

  c_run_timeout: cover property (expire_run);
  c_sleep_timeout: cover property (expire_sleep);
  c_startup_hold: cover property (in_hold ##1 in_run);
  c_wake_request: cover property (in_sleep && wake_request && !expire);

endmodule

// >>> osc_startup_model.sv
// Purpose: Oscillator start-up timer as seen by the watchdog
// Assumes: Oscillator stops while the core sleeps
// Notes:   slow stretches start-up so the counter hold is visible
`timescale 1ns/1ps
module osc_startup_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic sleeping,
  input  wire logic slow,
  output logic      done
);
  // ----------------------------------------------------------------
  // Start-up count
  // ----------------------------------------------------------------
  logic [5:0] cnt_r;

  // Reloaded all through Sleep, so counting starts at wake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      cnt_r <= 6'h00;
    else if (sleeping)
      cnt_r <= slow ? 6'h28 : 6'h03;
    else if (cnt_r != 6'h00)
      cnt_r <= cnt_r - 6'h01;
  end

  assign done = !sleeping && (cnt_r == 6'h00);
endmodule

// >>> sleep_aware_watchdog_bench.sv
// Purpose: Self-checking bench for the sleep-aware watchdog
// Assumes: Divider shortened to 4 cycles per tick
// Notes:   Inputs change on the falling edge only
`timescale 1ns/1ps
module sleep_aware_watchdog_bench;
  import watchdog_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic             clk, arst_n, swen, pload, slp, wk, clri, ofail;
  logic             slow, startup_done, sleeping, wake, wrst, tof, pdf;
  logic [1:0]       cfg;
  logic [SEL_W-1:0] sel;
  logic [2:0]       csel;
  logic [CNT_W-1:0] cnt, prev;
  int               n_mismatch = 0;
  int               compares = 0;
  int               i;

  sleep_aware_watchdog #(.TICK_DIV(4)) dut (
    .clk(clk), .arst_n(arst_n), .watchdog_enable_config(cfg),
    .software_watchdog_enable(swen), .watchdog_period_select(sel),
    .period_load(pload), .system_clock_sel(csel), .sleep_request(slp),
    .wake_request(wk), .oscillator_startup_timer_done(startup_done),
    .watchdog_clear_instruction(clri), .oscillator_fail(ofail),
    .watchdog_counter_r(cnt), .sleeping_r(sleeping), .wake_r(wake),
    .watchdog_reset_r(wrst), .timeout_flag_r(tof),
    .powerdown_flag_r(pdf));

  osc_startup_model osc (
    .clk(clk), .arst_n(arst_n), .sleeping(sleeping), .slow(slow),
    .done(startup_done));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Held for exactly one rising edge
  task pulse(input int k);
    @(negedge clk);
    case (k)
      0: slp = 1'b1;
      1: wk = 1'b1;
      2: clri = 1'b1;
      3: ofail = 1'b1;
      default: pload = 1'b1;
    endcase
    @(negedge clk);
    {slp, wk, clri, ofail, pload} = 5'h00;
  endtask

  task wait_wake(input int lim);
    int t;
    t = 0;
    while (wake !== 1'b1 && t < lim) begin
      @(negedge clk);
      t++;
    end
    check(wake, 1'b1);
  endtask

  task test_done;
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Whole run is about 8850 cycles
  initial begin
    #1_000_000;
    n_mismatch++;
    test_done;
  end

  initial begin
    arst_n = 1'b0;
    {swen, pload, slp, wk, clri, ofail, slow} = 7'h00;
    cfg = EN_ALWAYS;
    sel = 5'h00;
    csel = CLK_SECONDARY_OSC;
    cyc(6);
    check({cnt, sleeping, wrst, tof, pdf}, 32'h3);
    arst_n = 1'b1;
    i = 0;
    while (wrst !== 1'b1 && i < 8400) begin
      prev = cnt;
      @(negedge clk);
      i++;
    end
    check(wrst, 1'b1);
    check(prev, 19'h007FF);
    check({tof, pdf}, 2'h1);
    cfg = EN_OFF;
    cyc(20);
    check(cnt, 32'h0);
    cfg = EN_SOFTWARE;
    cyc(20);
    check(cnt, 32'h0);
    swen = 1'b1;
    cyc(20);
    check(cnt != 0, 1'b1);
    pulse(2);
    check(cnt, 32'h0);
    cyc(12);
    pulse(3);
    check(cnt, 32'h0);
    sel = 5'h02;
    pulse(4);
    cfg = EN_RUN_ONLY;
    cyc(6);
    pulse(0);
    check({cnt, sleeping, tof, pdf}, 32'h6);
    cyc(30);
    check({cnt, sleeping}, 32'h1);
    pulse(1);
    check({cnt, sleeping, wake}, 32'h1);
    cfg = EN_ALWAYS;
    // Crystal and non-crystal sources, one prompt start-up among them
    for (i = 0; i < 7; i++) begin
      csel = i[2:0];
      slow = (i != 5);
      pulse(2);
      cyc(3);
      pulse(0);
      check(cnt, 32'h0);
      wait_wake(40);
      check({wrst, tof, pdf, cnt}, 32'h0);
      cyc(12);
      check(cnt != 0, i < 4 || i == 5);
      cyc(40);
    end
    cyc(2);
    arst_n = 1'b0;
    cyc(1);
    check({cnt, sleeping, wrst, tof, pdf}, 32'h3);
    arst_n = 1'b1;
    cyc(2);
    test_done;
  end
endmodule
